// ==== src/vsp_bit_seq.sv ====
`timescale 1ns/1ns
`include "vsp_params.svh"
module vsp_bit_seq import vsp_pkg::*; #(
   parameter int BIT_CYCLES = `VSP_BIT_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic restart,
   input wire logic [15:0] fault_in,
   input wire logic scan_start,
   input wire logic scan_cmpl,
   output logic failed,
   output logic done_n,
   output logic busy,
   output logic [15:0] fault_flags
);
   // Refuse a self-test length the counter cannot time
   if (BIT_CYCLES < 1) begin : g_bad_cycles
      $error("BIT_CYCLES must be at least 1");
   end
   vsp_bit_st_e st_q;
   logic [31:0] cnt_q;
   logic [15:0] latched_q;
   wire [15:0] masked = fault_in & `VSP_ERR_VALID;
   wire timeup = (cnt_q == 32'(BIT_CYCLES - 1));
   wire any_fail = |(masked & ~`VSP_ERR_SCAN);
   // ---------------------------------------------
   // Self-test sequence
   // ---------------------------------------------
   // Restart acts as a clear too, so a backplane reset restarts the timer
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_q <= VSP_B_RUN;
         cnt_q <= 32'h0000_0000;
         failed <= 1'b1;
         done_n <= 1'b1;
         latched_q <= 16'h0000;
      end else if (restart) begin
         st_q <= VSP_B_RUN;
         cnt_q <= 32'h0000_0000;
         failed <= 1'b1;
         done_n <= 1'b1;
         latched_q <= 16'h0000;
      end else begin
         case (st_q)
            VSP_B_RUN: begin
               cnt_q <= cnt_q + 32'h0000_0001;
               if (timeup) begin
                  st_q <= VSP_B_DONE;
                  latched_q <= masked & ~`VSP_ERR_SCAN;
                  failed <= any_fail;
                  done_n <= ~any_fail;
               end
            end
            VSP_B_DONE: begin
               // Completion beats a new start in the same cycle
               if (scan_cmpl) done_n <= 1'b0;
               else if (scan_start) done_n <= 1'b1;
            end
            default: st_q <= VSP_B_IDLE;
         endcase
      end
   end
   // Scan-time faults show live, the rest only as latched by the test
   assign fault_flags = latched_q | (masked & `VSP_ERR_SCAN);
   assign busy = (st_q == VSP_B_RUN);
endmodule

// ==== src/vsp_bus_if.sv ====
`timescale 1ns/1ns
interface vsp_bus_if;
   logic [15:1] addr;
   logic [5:0] am;
   logic as_n;
   logic ds0_n;
   logic ds1_n;
   logic write_n;
   logic sysreset_n;
   logic [15:0] host_d_o;
   logic host_d_oe;
   logic [15:0] dev_d_o;
   logic dev_d_oe;
   logic dtack_oe;
   wire [15:0] d;
   wire dtack_n;
   // Pull-ups win when nobody drives; open collector acknowledge
   assign d = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : 16'hFFFF);
   assign dtack_n = ~dtack_oe;
   modport dev (input addr, am, as_n, ds0_n, ds1_n, write_n, sysreset_n, d, dtack_n,
      output dev_d_o, dev_d_oe, dtack_oe);
   modport host (output addr, am, as_n, ds0_n, ds1_n, write_n, sysreset_n, host_d_o, host_d_oe,
      input d, dtack_n);
endinterface

// ==== src/vsp_dev_end.sv ====
`timescale 1ns/1ns
`include "vsp_params.svh"
module vsp_dev_end import vsp_pkg::*; #(
   parameter int BIT_CYCLES = `VSP_BIT_CYCLES,
   parameter logic [15:0] BOARD_ID = 16'h5A5A, // arbitrary value
   parameter int NCH = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   vsp_bus_if.dev bus,
   input wire logic [10:0] base_jumper,
   input wire logic am_sup_sel,
   input wire logic proc_bus_hold,
   input wire logic [15:0] fault_in,
   input wire logic conv_we,
   input wire logic [2:0] conv_ch,
   input wire logic [15:0] conv_data,
   input wire logic [NCH-1:0] open_sensor,
   input wire logic scan_cmpl,
   output logic local_bus_grant,
   output logic scan_run,
   output logic [2:0] scan_mode,
   output logic [15:0] cj_temp,
   output logic bit_busy,
   output logic self_failed,
   output logic scan_done_flag_n,
   output logic [15:0] internal_fault_flags
);
   // Channel count is bounded by the eight result words
   if (NCH < 1 || NCH > 8) begin : g_bad_nch
      $error("NCH must be 1 to 8");
   end
   if (`VSP_RESP_CYCLES < 2) begin : g_bad_clk
      $error("Clock too slow for response time");
   end

   // ---------------------------------------------
   // Register storage and bus state
   // ---------------------------------------------
   logic [15:0] ram_q [16];
   vsp_dev_st_e st_q;
   logic [15:0] rdata_q;
   logic dtack_q;
   logic rd_q;
   logic sysrst_q;
   logic run_q;
   logic [2:0] mode_q;

   // Word index of a byte offset; register window is A04..A01
   function automatic logic [3:0] widx(input logic [4:0] ofs);
      widx = ofs[4:1];
   endfunction

   // ---------------------------------------------
   // Board selection decode
   // ---------------------------------------------
   wire [5:0] am_want = am_sup_sel ? `VSP_AM_SUP : `VSP_AM_NPRIV;
   wire addr_hit = (bus.addr[15:5] == base_jumper);
   wire am_hit = (bus.am == am_want);
   wire strobe = ~bus.ds0_n | ~bus.ds1_n;
   wire selected = ~bus.as_n & addr_hit & am_hit & strobe;
   wire granted = ~proc_bus_hold;
   wire [3:0] idx = bus.addr[4:1];
   wire is_wr = ~bus.write_n;
   wire sys_rst = sysrst_q;

   // Byte lane merge of a write: DS1 upper, DS0 lower
   wire [15:0] lane_mask = {{8{~bus.ds1_n}}, {8{~bus.ds0_n}}};
   wire [15:0] wr_word = (bus.d & lane_mask) | (ram_q[idx] & ~lane_mask);
   wire do_write = (st_q == VSP_D_XFER) & is_wr;

   // ---------------------------------------------
   // Read data selection
   // ---------------------------------------------
   wire [15:0] csr_rd = {8'h00, scan_done_flag_n, self_failed, 2'b00, mode_q, run_q};
   wire is_cdr = idx[3];
   wire [2:0] ch = idx[2:0];
   wire ch_open = (32'(ch) < NCH) ? open_sensor[ch] : 1'b0;
   wire [15:0] cdr_rd = ch_open ? `VSP_NEG_FS : ram_q[idx];
   wire [15:0] rd_word =
      (idx == widx(`VSP_OFS_CSR)) ? csr_rd :
      (idx == widx(`VSP_OFS_ID)) ? BOARD_ID :
      (idx == widx(`VSP_OFS_ERR)) ? internal_fault_flags :
      is_cdr ? cdr_rd : ram_q[idx];

   // ---------------------------------------------
   // Control register side effects
   // ---------------------------------------------
   wire csr_wr = do_write & (idx == widx(`VSP_OFS_CSR)) & ~bus.ds0_n;
   wire [2:0] new_mode = bus.d[`VSP_CSR_MODE_LO +: 3];
   wire start_req = csr_wr & bus.d[`VSP_CSR_START] & ~bit_busy;
   wire cont_mode = (mode_q == VSP_M_CONT);

   // ---------------------------------------------
   // Backplane reset capture
   // ---------------------------------------------
   // Reset line is treated as synchronous; one flop gives a clean clear
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) sysrst_q <= 1'b0;
      else sysrst_q <= ~bus.sysreset_n;
   end

   // ---------------------------------------------
   // Bus handshake state machine
   // ---------------------------------------------
   // Two cycles from strobe to acknowledge keeps inside the response time
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_q <= VSP_D_IDLE;
         dtack_q <= 1'b0;
         rd_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else if (sys_rst) begin
         st_q <= VSP_D_IDLE;
         dtack_q <= 1'b0;
         rd_q <= 1'b0;
      end else begin
         case (st_q)
            VSP_D_IDLE: begin
               if (selected & granted) begin
                  st_q <= VSP_D_XFER;
                  rd_q <= ~is_wr;
               end
            end
            VSP_D_XFER: begin
               rdata_q <= rd_word;
               dtack_q <= 1'b1;
               st_q <= VSP_D_ACK;
            end
            VSP_D_ACK: begin
               if (~strobe) begin
                  dtack_q <= 1'b0;
                  rd_q <= 1'b0;
                  st_q <= VSP_D_IDLE;
               end
            end
            default: st_q <= VSP_D_IDLE;
         endcase
      end
   end

   // ---------------------------------------------
   // Register storage
   // ---------------------------------------------
   // Storage mirrors the shared RAM of the board; rst clears it, a backplane reset does not
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_reg
         wire host_hit = do_write & (idx == 4'(gi));
         wire conv_hit = conv_we & (gi >= 8) & (conv_ch == 3'(gi - 8));
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) ram_q[gi] <= 16'h0000;
            else if (conv_hit) ram_q[gi] <= conv_data;
            else if (host_hit) ram_q[gi] <= wr_word;
         end
      end
   endgenerate

   // ---------------------------------------------
   // Scan mode and run control
   // ---------------------------------------------
   // Single scan stops on completion; continuous runs until mode changes
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         run_q <= 1'b0;
         mode_q <= VSP_M_IDLE;
      end else if (sys_rst) begin
         run_q <= 1'b0;
         mode_q <= VSP_M_IDLE;
      end else if (csr_wr) begin
         mode_q <= new_mode;
         if (start_req) run_q <= 1'b1;
         else if (new_mode != mode_q) run_q <= 1'b0;
      end else if (scan_cmpl & ~cont_mode) begin
         run_q <= 1'b0;
      end
   end

   // ---------------------------------------------
   // Self-test engine
   // ---------------------------------------------
   vsp_bit_seq #(
      .BIT_CYCLES(BIT_CYCLES)
   ) u_bit (
      .core_clk(core_clk),
      .rst(rst),
      .restart(sys_rst),
      .fault_in(fault_in),
      .scan_start(start_req),
      .scan_cmpl(scan_cmpl & run_q),
      .failed(self_failed),
      .done_n(scan_done_flag_n),
      .busy(bit_busy),
      .fault_flags(internal_fault_flags)
   );

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   assign local_bus_grant = granted;
   assign scan_run = run_q;
   assign scan_mode = mode_q;
   assign cj_temp = ram_q[widx(`VSP_OFS_CJ)];
   assign bus.dtack_oe = dtack_q;
   // Drive the data lines only while answering a read
   assign bus.dev_d_oe = rd_q & dtack_q & strobe & bus.write_n;
   assign bus.dev_d_o = rdata_q;
endmodule

// ==== src/vsp_host_end.sv ====
`timescale 1ns/1ns
`include "vsp_params.svh"
module vsp_host_end import vsp_pkg::*; #(
   parameter int RST_CYCLES = 4
) (
   input wire logic core_clk,
   input wire logic rst,
   vsp_bus_if.host bus,
   input wire logic [2:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata
);
   // Reset pulse length must fit the 8-bit counter
   if (RST_CYCLES < 1 || RST_CYCLES > 255) begin : g_bad_rst
      $error("RST_CYCLES must be 1 to 255");
   end
   // ---------------------------------------------
   // Command registers
   // ---------------------------------------------
   localparam logic [2:0] HR_CMD = 3'h0;
   localparam logic [2:0] HR_WDATA = 3'h1;
   localparam logic [2:0] HR_RDATA = 3'h2;
   localparam logic [2:0] HR_STAT = 3'h3;
   localparam logic [2:0] HR_BASE = 3'h4;
   vsp_host_st_e st_q;
   logic [15:0] wdata_q;
   logic [15:0] rdata_q;
   logic [15:0] base_q;
   logic [3:0] idx_q;
   logic wr_q;
   logic [1:0] lanes_q;
   logic done_q;
   logic [7:0] cnt_q;
   // Command word: [3:0] index, [4] write, [6:5] lanes, [7] go, [8] backplane reset
   wire cmd_wr = reg_wr & (reg_addr == HR_CMD);
   wire idle = (st_q == VSP_H_IDLE);
   wire go = cmd_wr & reg_wdata[7] & idle;
   wire rst_go = cmd_wr & reg_wdata[8] & idle;
   wire ack = ~bus.dtack_n;
   wire [15:0] stat = {13'h0000, done_q, ~idle, base_q[0]};
   wire [15:0] rd_sel = (reg_addr == HR_WDATA) ? wdata_q :
      (reg_addr == HR_RDATA) ? rdata_q :
      (reg_addr == HR_STAT) ? stat :
      (reg_addr == HR_BASE) ? base_q : 16'h0000;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wdata_q <= 16'h0000;
         base_q <= 16'h0000;
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= reg_rd ? rd_sel : 16'h0000;
         if (reg_wr & (reg_addr == HR_WDATA)) wdata_q <= reg_wdata;
         if (reg_wr & (reg_addr == HR_BASE)) base_q <= reg_wdata;
      end
   end
   // ---------------------------------------------
   // Bus master cycle
   // ---------------------------------------------
   // No timeout: an unmatched address stalls until the next reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_q <= VSP_H_IDLE;
         idx_q <= 4'h0;
         wr_q <= 1'b0;
         lanes_q <= 2'b00;
         done_q <= 1'b0;
         rdata_q <= 16'h0000;
         cnt_q <= 8'h00;
      end else begin
         case (st_q)
            VSP_H_IDLE: begin
               if (go) begin
                  st_q <= VSP_H_ADDR;
                  idx_q <= reg_wdata[3:0];
                  wr_q <= reg_wdata[4];
                  lanes_q <= reg_wdata[6:5];
                  done_q <= 1'b0;
               end else if (rst_go) begin
                  st_q <= VSP_H_RST;
                  cnt_q <= 8'(RST_CYCLES);
                  done_q <= 1'b0;
               end
            end
            VSP_H_ADDR: st_q <= VSP_H_STRB;
            VSP_H_STRB: begin
               if (ack) begin
                  rdata_q <= bus.d;
                  st_q <= VSP_H_REL;
               end
            end
            VSP_H_REL: begin
               if (~ack) begin
                  st_q <= VSP_H_IDLE;
                  done_q <= 1'b1;
               end
            end
            VSP_H_RST: begin
               cnt_q <= cnt_q - 8'h01;
               if (cnt_q == 8'h01) begin
                  st_q <= VSP_H_IDLE;
                  done_q <= 1'b1;
               end
            end
            default: st_q <= VSP_H_IDLE;
         endcase
      end
   end
   // ---------------------------------------------
   // Pin drive
   // ---------------------------------------------
   wire in_cyc = (st_q == VSP_H_ADDR) | (st_q == VSP_H_STRB);
   wire strb = (st_q == VSP_H_STRB);
   assign bus.addr = {base_q[15:5], idx_q};
   assign bus.am = base_q[0] ? `VSP_AM_SUP : `VSP_AM_NPRIV;
   assign bus.as_n = ~in_cyc;
   assign bus.write_n = ~(in_cyc & wr_q);
   assign bus.ds0_n = ~(strb & lanes_q[0]);
   assign bus.ds1_n = ~(strb & lanes_q[1]);
   assign bus.host_d_oe = in_cyc & wr_q;
   assign bus.host_d_o = wdata_q;
   assign bus.sysreset_n = ~(st_q == VSP_H_RST);
endmodule

// ==== src/vsp_params.svh ====
`ifndef VSP_PARAMS_SVH
`define VSP_PARAMS_SVH

// ---------------------------------------------
// Register offsets (byte address relative)
// ---------------------------------------------
`define VSP_OFS_CSR 5'h00
`define VSP_OFS_ID 5'h02
`define VSP_OFS_ERR 5'h04
`define VSP_OFS_CJ 5'h0E
`define VSP_OFS_CDR 5'h10
// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define VSP_CSR_START 0
`define VSP_CSR_MODE_LO 1
`define VSP_CSR_FAILED 6
`define VSP_CSR_DONE_N 7
`define VSP_ERR_ADC 0
`define VSP_ERR_NVS 1
`define VSP_ERR_CSUM 2
`define VSP_ERR_RAM 4
`define VSP_ERR_TEMP 6
`define VSP_ERR_IO 8
`define VSP_ERR_WDOG 9
`define VSP_ERR_REF 10
`define VSP_ERR_CAL 11
`define VSP_ERR_VALID 16'h0F57
`define VSP_ERR_SCAN 16'h0A03
// ---------------------------------------------
// Values and timing
// ---------------------------------------------
`define VSP_NEG_FS 16'h8000
`define VSP_AM_SUP 6'h2D
`define VSP_AM_NPRIV 6'h29
`define VSP_CLK_NS 100
`define VSP_BIT_MS 1000
`define VSP_BIT_CYCLES (`VSP_BIT_MS * 1000000 / `VSP_CLK_NS)
`define VSP_RESP_NS 300
`define VSP_RESP_CYCLES (`VSP_RESP_NS / `VSP_CLK_NS)
`endif

// ==== src/vsp_pkg.sv ====
package vsp_pkg;
   typedef enum logic [1:0] {
      VSP_D_IDLE = 2'b00,
      VSP_D_XFER = 2'b01,
      VSP_D_ACK = 2'b10
   } vsp_dev_st_e;
   typedef enum logic [2:0] {
      VSP_H_IDLE = 3'b000,
      VSP_H_ADDR = 3'b001,
      VSP_H_STRB = 3'b010,
      VSP_H_REL = 3'b011,
      VSP_H_RST = 3'b100
   } vsp_host_st_e;
   typedef enum logic [1:0] {
      VSP_B_IDLE = 2'b00,
      VSP_B_RUN = 2'b01,
      VSP_B_DONE = 2'b10
   } vsp_bit_st_e;
   typedef enum logic [2:0] {
      VSP_M_IDLE = 3'b000,
      VSP_M_SINGLE = 3'b001,
      VSP_M_CONT = 3'b010
   } vsp_mode_e;
endpackage

// ==== tb/vme_slave_port_selftest_status_tb.sv ====
`timescale 1ns/1ns
module vme_slave_port_selftest_status_tb import vsp_pkg::*;;
   // ---------------------------------------------
   // Signals and instances
   // ---------------------------------------------
   localparam int BITC = 20; // Short self-test keeps the run brief
   localparam logic [10:0] BASE = 11'h2A5;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic am_sup_sel = 1'b0;
   logic proc_bus_hold = 1'b0;
   logic [15:0] fault_in = 16'h0000;
   logic conv_we = 1'b0;
   logic [2:0] conv_ch = 3'h0;
   logic [15:0] conv_data = 16'h0000;
   logic [7:0] open_sensor = 8'h04; // Open input must not fail self-test
   logic scan_cmpl = 1'b0;
   logic local_bus_grant, scan_run, bit_busy, self_failed, scan_done_flag_n;
   logic [2:0] scan_mode;
   logic [15:0] cj_temp, internal_fault_flags, rv;
   int bad_count = 0;
   int compares = 0;
   int cyc = 0;
   vsp_bus_if bus_if ();
   // Board identity value is arbitrary
   vsp_dev_end #(.BIT_CYCLES(BITC), .BOARD_ID(16'h1234)) vsp_dev_end_inst (.core_clk(core_clk), .rst(rst),
      .bus(bus_if.dev), .base_jumper(BASE), .am_sup_sel(am_sup_sel), .proc_bus_hold(proc_bus_hold),
      .fault_in(fault_in), .conv_we(conv_we), .conv_ch(conv_ch), .conv_data(conv_data), .open_sensor(open_sensor),
      .scan_cmpl(scan_cmpl), .local_bus_grant(local_bus_grant), .scan_run(scan_run), .scan_mode(scan_mode),
      .cj_temp(cj_temp), .bit_busy(bit_busy), .self_failed(self_failed), .scan_done_flag_n(scan_done_flag_n),
      .internal_fault_flags(internal_fault_flags));
   vsp_host_end vsp_host_end_inst (.core_clk(core_clk), .rst(rst), .bus(bus_if.host), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   vsp_bus_asserts vsp_bus_asserts_inst (.core_clk(core_clk), .rst(rst), .addr(bus_if.addr), .am(bus_if.am),
      .as_n(bus_if.as_n), .ds0_n(bus_if.ds0_n), .ds1_n(bus_if.ds1_n), .write_n(bus_if.write_n),
      .sysreset_n(bus_if.sysreset_n), .host_d_oe(bus_if.host_d_oe), .dev_d_oe(bus_if.dev_d_oe),
      .dtack_oe(bus_if.dtack_oe), .base_jumper(BASE), .am_sup_sel(am_sup_sel), .proc_bus_hold(proc_bus_hold));

   // Clock and hang guard
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   // ---------------------------------------------
   // Access tasks
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rwr(input logic [2:0] a, input logic [15:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rrd(input logic [2:0] a, output logic [15:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // Launch one backplane cycle; lanes are {upper, lower}
   task automatic go(input logic [3:0] w, input logic wr, input logic [1:0] ln, input logic [15:0] v);
      rwr(3'd1, v);
      rwr(3'd0, {8'h00, 1'b1, ln, wr, w});
   endtask
   // Poll busy with a bound, then fetch the last read word
   task automatic fin();
      int n;
      n = 0;
      rv = 16'h0002;
      while (rv[1] && n < 100) begin
         rrd(3'd3, rv);
         n++;
      end
      chk("host busy", 16'(n == 100), 16'h0000);
      rrd(3'd2, rv);
   endtask
   task automatic vme(input logic [3:0] w, input logic wr, input logic [1:0] ln, input logic [15:0] v);
      go(w, wr, ln, v);
      fin();
   endtask
   task automatic scan_end();
      @(posedge core_clk);
      scan_cmpl <= 1'b1;
      @(posedge core_clk);
      scan_cmpl <= 1'b0;
      @(posedge core_clk);
      #1;
   endtask
   // Backplane reset from the host, then wait out self-test
   task automatic sys_reset();
      rwr(3'd0, 16'h0100);
      repeat (3) @(posedge core_clk);
      #1 chk("failed during test", self_failed, 1);
      chk("busy during test", bit_busy, 1);
      repeat (BITC + 15) @(posedge core_clk);
      #1;
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ---------------------------------------------
   // Test sequence
   // ---------------------------------------------
   initial begin
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      #1 chk("failed at start", self_failed, 1);
      chk("done_n at start", scan_done_flag_n, 1);
      rwr(3'd4, {BASE, 5'h00});
      repeat (BITC + 5) @(posedge core_clk);
      #1 chk("failed after pass", self_failed, 0);
      // A passing test leaves the scan-done flag high
      chk("done_n after pass", scan_done_flag_n, 1);
      chk("busy after pass", bit_busy, 0);
      vme(4'd0, 1'b0, 2'b11, 16'h0000);
      chk("status flags", rv & 16'h00C0, 16'h0080);
      vme(4'd1, 1'b0, 2'b11, 16'h0000);
      chk("board id", rv, 16'h1234);
      vme(4'd2, 1'b0, 2'b11, 16'h0000);
      chk("fault word clean", rv, 16'h0000);
      $display("test selftest done");
      // Cold junction word and byte lanes; 527.67 degrees Rankine
      vme(4'd7, 1'b1, 2'b11, 16'hCE1F);
      chk("cj word", cj_temp, 16'hCE1F);
      vme(4'd7, 1'b0, 2'b11, 16'h0000);
      chk("cj readback", rv, 16'hCE1F);
      vme(4'd7, 1'b1, 2'b01, 16'h1234);
      chk("lower lane", cj_temp, 16'hCE34);
      vme(4'd7, 1'b1, 2'b10, 16'h5678);
      chk("upper lane", cj_temp, 16'h5634);
      $display("test lanes done");
      // Host held off while the resident processor owns the bus
      @(posedge core_clk);
      proc_bus_hold <= 1'b1;
      go(4'd7, 1'b1, 2'b11, 16'h0BB8);
      repeat (10) @(posedge core_clk);
      #1 chk("grant", local_bus_grant, 0);
      chk("held dtack", bus_if.dtack_n, 1);
      chk("held store", cj_temp, 16'h5634);
      @(posedge core_clk);
      proc_bus_hold <= 1'b0;
      fin();
      chk("grant back", local_bus_grant, 1);
      chk("late store", cj_temp, 16'h0BB8);
      $display("test grant done");
      // Converted data and an open sensor
      @(posedge core_clk);
      conv_ch <= 3'd2;
      conv_data <= 16'h0123;
      conv_we <= 1'b1;
      @(posedge core_clk);
      conv_we <= 1'b0;
      vme(4'd10, 1'b0, 2'b11, 16'h0000);
      chk("open channel", rv, 16'h8000);
      @(posedge core_clk);
      open_sensor <= 8'h00;
      vme(4'd10, 1'b0, 2'b11, 16'h0000);
      chk("closed channel", rv, 16'h0123);
      $display("test channel done");
      // Single scan stops, continuous runs until mode change
      vme(4'd0, 1'b1, 2'b01, 16'h0003);
      chk("single run", scan_run, 1);
      chk("single mode", 16'(scan_mode), 16'(VSP_M_SINGLE));
      scan_end();
      chk("single stop", scan_run, 0);
      vme(4'd0, 1'b1, 2'b01, 16'h0005);
      scan_end();
      chk("cont run", scan_run, 1);
      vme(4'd0, 1'b1, 2'b01, 16'h0002);
      chk("cont stop", scan_run, 0);
      $display("test modes done");
      // Self-test failures reported in the fault word
      @(posedge core_clk);
      fault_in <= 16'hF0B0;
      sys_reset();
      chk("failed set", self_failed, 1);
      chk("done_n low", scan_done_flag_n, 0);
      chk("ram fault only", internal_fault_flags, 16'h0010);
      vme(4'd2, 1'b0, 2'b11, 16'h0000);
      chk("fault word", rv, 16'h0010);
      @(posedge core_clk);
      fault_in <= 16'hFFFF;
      sys_reset();
      chk("all faults", internal_fault_flags, 16'h0F57);
      @(posedge core_clk);
      fault_in <= 16'h0000;
      $display("test faults done");
      // Address and modifier mismatch are ignored
      for (int i = 0; i < 2; i++) begin
         rwr(3'd4, {BASE ^ 11'(i == 0), 4'h0, 1'(i == 1)});
         go(4'd7, 1'b1, 2'b11, 16'hDEAD);
         repeat (20) @(posedge core_clk);
         #1 chk("ignored dtack", bus_if.dtack_n, 1);
         chk("ignored store", 16'(cj_temp == 16'hDEAD), 16'h0000);
         @(posedge core_clk);
         rst <= 1'b1;
         repeat (2) @(posedge core_clk);
         rst <= 1'b0;
      end
      @(posedge core_clk);
      am_sup_sel <= 1'b1;
      rwr(3'd4, {BASE, 5'h01});
      repeat (BITC + 5) @(posedge core_clk);
      #1 chk("pass after reset", self_failed, 0);
      vme(4'd7, 1'b1, 2'b11, 16'h2468);
      chk("supervisory store", cj_temp, 16'h2468);
      $display("test select done");
      tally_and_finish();
   end
endmodule

// ==== tb/vsp_bus_asserts.sv ====
`timescale 1ns/1ns
module vsp_bus_asserts (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [15:1] addr,
   input wire logic [5:0] am,
   input wire logic as_n,
   input wire logic ds0_n,
   input wire logic ds1_n,
   input wire logic write_n,
   input wire logic sysreset_n,
   input wire logic host_d_oe,
   input wire logic dev_d_oe,
   input wire logic dtack_oe,
   input wire logic [10:0] base_jumper,
   input wire logic am_sup_sel,
   input wire logic proc_bus_hold
);
   // ---------------------------------------------
   // Bus handshake properties
   // ---------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   // Decoded select terms, as the board comparator sees them
   wire logic [5:0] am_want = am_sup_sel ? 6'h2D : 6'h29;
   wire logic addr_hit = !as_n && (addr[15:5] == base_jumper);
   wire logic strb = !(ds0_n && ds1_n);

   addr_match_a:
      assert property ($rose(dtack_oe) |-> $past(addr_hit)) else $error("acknowledge without address match");
   am_match_a:
      assert property ($rose(dtack_oe) |-> $past(am) == am_want) else $error("acknowledge on wrong modifier");
   grant_block_a:
      assert property (proc_bus_hold && !dtack_oe |=> !dtack_oe) else $error("acknowledge while bus held");
   ack_release_a:
      assert property (dtack_oe && !strb |-> ##[1:2] !dtack_oe) else $error("acknowledge not released");
   ack_stand_a:
      assert property (dtack_oe && strb && sysreset_n |=> dtack_oe) else $error("acknowledge dropped early");
   ack_time_a:
      assert property (addr_hit && am == am_want && strb && !proc_bus_hold && !dtack_oe && sysreset_n
         |-> ##[1:3] dtack_oe) else $error("acknowledge later than 300 ns");
   read_drive_a:
      assert property (dev_d_oe |-> write_n && dtack_oe && strb) else $error("data driven outside read");
   no_fight_a:
      assert property (!(dev_d_oe && host_d_oe)) else $error("both ends drive data");
   sysreset_idle_a:
      assert property (!sysreset_n [*3] |-> !dtack_oe && !dev_d_oe) else $error("busy during system reset");
endmodule
